/* File: hdl/adc_compute_pkg.sv */
/*
  Package for the converter computation and control block: register offsets, field positions,
  reset values, stage and mode encodings and the carrier struct of the analog top-level port.
  Assumes a byte-wide register port with a 12-bit address and one system clock.
*/
package adc_compute_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CONVERSION_CONTROL = 12'h111;
  localparam logic [11:0] OFS_SAMPLING_CONTROL   = 12'h112;
  localparam logic [11:0] OFS_COMPUTE_CONTROL    = 12'h113;
  localparam logic [11:0] OFS_THRESHOLD_CONTROL  = 12'h114;
  localparam logic [11:0] OFS_CONVERTER_STATUS   = 12'h115;
  localparam logic [11:0] OFS_REFERENCE_SELECT   = 12'h116;
  localparam logic [11:0] OFS_CLOCK_DIVIDER      = 12'h118;
  localparam logic [11:0] OFS_LOWER_LIMIT_L      = 12'h08C;
  localparam logic [11:0] OFS_LOWER_LIMIT_H      = 12'h08D;
  localparam logic [11:0] OFS_UPPER_LIMIT_L      = 12'h08E;
  localparam logic [11:0] OFS_UPPER_LIMIT_H      = 12'h08F;
  localparam logic [11:0] OFS_FILTER_L           = 12'h094;
  localparam logic [11:0] OFS_FILTER_H           = 12'h095;
  localparam logic [11:0] OFS_ACCUM_L            = 12'h096;
  localparam logic [11:0] OFS_ACCUM_H            = 12'h097;
  localparam logic [11:0] OFS_ACCUM_U            = 12'h098;
  localparam logic [11:0] OFS_REPEAT_COUNTER     = 12'h099;
  localparam logic [11:0] OFS_REPEAT_TARGET      = 12'h09A;
  localparam logic [11:0] OFS_PREVIOUS_L         = 12'h09B;
  localparam logic [11:0] OFS_PREVIOUS_H         = 12'h09C;
  localparam logic [11:0] OFS_RESULT_L           = 12'h09D;
  localparam logic [11:0] OFS_RESULT_H           = 12'h09E;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_ENABLE        = 7;
  localparam int BIT_CONTINUOUS    = 6;
  localparam int BIT_CLOCK_SELECT  = 4;
  localparam int BIT_GO            = 0;
  localparam int BIT_PRECHARGE_POLARITY          = 7;
  localparam int BIT_INVERTED_PRECHARGE_ENABLE          = 6;
  localparam int BIT_GUARD_POLARITY          = 5;
  localparam int BIT_DOUBLE_SAMPLE_ENABLE          = 0;
  localparam int BIT_PREVIOUS_SOURCE_SELECT          = 7;
  localparam int POS_SHIFT         = 4;
  localparam int BIT_ACCUMULATOR_CLEAR_CMD          = 3;
  localparam int POS_MODE          = 0;
  localparam int POS_ERRSEL        = 4;
  localparam int BIT_SOI           = 3;
  localparam int BIT_OVERFLOW      = 7;
  localparam int BIT_UPPER_FLAG    = 6;
  localparam int BIT_LOWER_FLAG    = 5;
  localparam int BIT_COMPUTATION_STATUS          = 4;
  localparam int BIT_NEGATIVE_REFERENCE_SELECT          = 4;

  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [2:0] MODE_BASIC      = 3'h0;
  localparam logic [2:0] MODE_ACCUMULATE = 3'h1;
  localparam logic [2:0] MODE_AVERAGE    = 3'h2;
  localparam logic [2:0] MODE_BURST      = 3'h3;
  localparam logic [2:0] MODE_LOWPASS    = 3'h4;

  localparam logic [2:0] THR_NEVER   = 3'h0;
  localparam logic [2:0] THR_BELOW   = 3'h1;
  localparam logic [2:0] THR_ATLEAST = 3'h2;
  localparam logic [2:0] THR_INSIDE  = 3'h3;
  localparam logic [2:0] THR_OUTSIDE = 3'h4;
  localparam logic [2:0] THR_ATMOST  = 3'h5;
  localparam logic [2:0] THR_ABOVE   = 3'h6;
  localparam logic [2:0] THR_ALWAYS  = 3'h7;

  // Stage lengths in conversion-clock ticks
  localparam int PRECHARGE_TICKS   = 4;
  localparam int ACQUISITION_TICKS = 8;

  typedef enum logic [2:0] {IDLE, PRE1, ACQ1, CONV1, PRE2, ACQ2, CONV2} stage_e;

  typedef struct packed {
    logic precharge_level;
    logic guard_level;
    logic neg_ref_external;
    logic conv_start;
    logic conv_clk;
    logic busy;
  } analog_ctrl_s;

endpackage

/* File: hdl/adc_compute_control.sv */
/*
  Control, computation and status logic of a successive-approximation converter with computation.
  Assumes the analog core answers conv_start with one conv_done pulse carrying a 12-bit sample,
  that all inputs are synchronous to i_clk, and that the dedicated oscillator arrives as a level.
*/
// How it works
// R01: Inverted precharge flips second-pass polarities
// R02: Guard starts at guard polarity level
// R03: Double sample: two passes, first to previous
// R04: Previous takes filter or result at start
// R05: Low-pass time constant is two to shift
// R06: Filter equals accumulator shifted right
// R07: Software sets repeat count, avoids shift seven
// R08: Clear command zeroes accumulator, overflow, counter
// R09: Clear command drops only when clearing done
// R10: Mode field picks computation mode
// R11: Stop-on-interrupt ends continuous run on hit
// R12: Otherwise go stays until software clears
// R13: Threshold mode picks interrupt condition
// R14: Overflow flag reports accumulator overflow
// R15: Upper and lower threshold flags
// R16: Computation status set on any update
// R17: Cycle status field reports current stage
// R18: Divider gives oscillator over twice divider plus one
// R19: Negative reference select drives reference route
// R20: Single mode clears go on completion
// R21: Divider counter toggles clock at wrap
`timescale 1ns/100ps
module adc_compute_control
#(
  parameter int PRE_TICKS = adc_compute_pkg::PRECHARGE_TICKS,
  parameter int ACQ_TICKS = adc_compute_pkg::ACQUISITION_TICKS
) (
  // Clock, reset, enable
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_ce,
  // Register port
  input  wire logic [11:0]                  i_addr,
  input  wire logic [7:0]                   i_wr_data,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [7:0]                   o_rd_data,
  // Analog core
  input  wire logic                         i_dedicated_osc,
  input  wire logic                         i_conv_done,
  input  wire logic [11:0]                  i_conv_data,
  output adc_compute_pkg::analog_ctrl_s     o_analog,
  output logic                              o_threshold_event
);
  import adc_compute_pkg::*;

  if (PRE_TICKS < 1 || PRE_TICKS > 8191 || ACQ_TICKS < 1 || ACQ_TICKS > 8191) begin : g_bad_ticks
    $error("Stage tick counts out of range");
  end

  localparam logic [12:0] PRE_LOAD = 13'(PRE_TICKS);
  localparam logic [12:0] ACQ_LOAD = 13'(ACQ_TICKS);

  typedef struct packed {
    stage_e      stage;
    logic [12:0] stage_cnt;
    logic [5:0]  div_cnt;
    logic        conv_clk;
    logic        osc_prev;
    logic [7:0]  conv_ctl;
    logic [7:0]  samp_ctl;
    logic [7:0]  comp_ctl;
    logic [7:0]  thr_ctl;
    logic [7:0]  ref_sel;
    logic [7:0]  clk_div;
    logic [7:0]  repeat_target;
    logic [7:0]  repeat_counter;
    logic [15:0] upper_limit;
    logic [15:0] lower_limit;
    logic [15:0] result;
    logic [15:0] previous;
    logic [15:0] filter_output;
    logic [17:0] accumulator;
    logic        accumulator_overflow;
    logic        upper_flag;
    logic        lower_flag;
    logic        computation_status;
    logic        thr_event;
    logic        conv_start;
    logic        precharge_lvl;
    logic        guard_lvl;
    logic        busy;
    logic [7:0]  rd_data;
  } state_s;

  state_s st;
  state_s next_st;
  logic   tick;
  logic   finish;
  logic   check;
  logic   hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [2:0] stage_code(input stage_e s);
    unique case (s)
      IDLE:  stage_code = 3'h0;
      PRE1:  stage_code = 3'h1;
      ACQ1:  stage_code = 3'h2;
      CONV1: stage_code = 3'h3;
      PRE2:  stage_code = 3'h5;
      ACQ2:  stage_code = 3'h6;
      CONV2: stage_code = 3'h7;
      default: stage_code = 3'h0;
    endcase
  endfunction

  function automatic logic thr_hit(input logic [2:0] m, input logic [15:0] err,
                                   input logic [15:0] uth, input logic [15:0] lth);
    logic above;
    logic below;
    above = $signed({1'b0, err}) > $signed({uth[15], uth});
    below = $signed({1'b0, err}) < $signed({lth[15], lth});
    unique case (m)
      THR_ALWAYS:  thr_hit = 1'b1;
      THR_ABOVE:   thr_hit = above;
      THR_ATMOST:  thr_hit = !above;
      THR_OUTSIDE: thr_hit = below || above;
      THR_INSIDE:  thr_hit = ($signed({1'b0, err}) > $signed({lth[15], lth})) && !above && (err != uth);
      THR_ATLEAST: thr_hit = !below;
      THR_BELOW:   thr_hit = below;
      THR_NEVER:   thr_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] shift_out(input logic [17:0] acc, input logic [2:0] sh);
    logic [17:0] t;
    t = acc >> sh;
    shift_out = t[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [17:0] sample;
    logic [18:0] sum;
    logic [7:0]  cnt_inc;
    logic [2:0]  mode;
    logic [2:0]  sh;
    logic [15:0] err;
    logic        pol_flip;
    sample   = {6'h00, i_conv_data};
    sum      = 19'h00000;
    cnt_inc  = (st.repeat_counter == 8'hFF) ? 8'hFF : st.repeat_counter + 8'h01;
    mode     = st.comp_ctl[POS_MODE +: 3];
    sh       = st.comp_ctl[POS_SHIFT +: 3];
    err      = 16'h0000;
    pol_flip = st.samp_ctl[BIT_INVERTED_PRECHARGE_ENABLE] && st.samp_ctl[BIT_DOUBLE_SAMPLE_ENABLE];
    tick     = 1'b0;
    finish   = 1'b0;
    check    = 1'b0;
    hit      = 1'b0;
    next_st  = st;
    next_st.conv_start = 1'b0;
    next_st.thr_event  = 1'b0;
    next_st.rd_data    = 8'h00;
    next_st.osc_prev   = i_dedicated_osc;

    // Conversion clock
    if (st.conv_ctl[BIT_CLOCK_SELECT]) begin
      tick = i_dedicated_osc && !st.osc_prev;
    end else if (st.div_cnt >= st.clk_div[5:0]) begin
      next_st.div_cnt  = 6'h00; // R21
      next_st.conv_clk = !st.conv_clk; // R18
      tick             = !st.conv_clk;
    end else begin
      next_st.div_cnt = st.div_cnt + 6'h01; // R18
    end

    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        OFS_CONVERSION_CONTROL: next_st.conv_ctl = i_wr_data & 8'hD1;
        OFS_SAMPLING_CONTROL:   next_st.samp_ctl = i_wr_data & 8'hE1;
        OFS_COMPUTE_CONTROL:    next_st.comp_ctl = {i_wr_data[7:4], st.comp_ctl[BIT_ACCUMULATOR_CLEAR_CMD] | i_wr_data[3],
                                                    i_wr_data[2:0]};
        OFS_THRESHOLD_CONTROL:  next_st.thr_ctl  = i_wr_data & 8'h7F;
        OFS_CONVERTER_STATUS:   next_st.computation_status     = st.computation_status & i_wr_data[BIT_COMPUTATION_STATUS];
        OFS_REFERENCE_SELECT:   next_st.ref_sel  = i_wr_data & 8'h13;
        OFS_CLOCK_DIVIDER:      next_st.clk_div  = i_wr_data & 8'h3F;
        OFS_REPEAT_TARGET:      next_st.repeat_target = i_wr_data;
        OFS_REPEAT_COUNTER:     next_st.repeat_counter = i_wr_data;
        OFS_LOWER_LIMIT_L:      next_st.lower_limit[7:0]  = i_wr_data;
        OFS_LOWER_LIMIT_H:      next_st.lower_limit[15:8] = i_wr_data;
        OFS_UPPER_LIMIT_L:      next_st.upper_limit[7:0]  = i_wr_data;
        OFS_UPPER_LIMIT_H:      next_st.upper_limit[15:8] = i_wr_data;
        default: ;
      endcase
    end

    // Sequencer
    if (st.stage != IDLE && !st.conv_ctl[BIT_GO]) begin
      next_st.stage = IDLE; // Software abort: no computation
    end else begin
      unique case (st.stage)
        IDLE: begin
          if (st.conv_ctl[BIT_GO] && st.conv_ctl[BIT_ENABLE]) begin
            next_st.previous      = st.comp_ctl[BIT_PREVIOUS_SOURCE_SELECT] ? st.filter_output : st.result; // R04
            next_st.stage         = PRE1;
            next_st.stage_cnt     = PRE_LOAD;
            next_st.precharge_lvl = st.samp_ctl[BIT_PRECHARGE_POLARITY];
            next_st.guard_lvl     = st.samp_ctl[BIT_GUARD_POLARITY]; // R02
          end
        end
        PRE1, PRE2: begin
          if (tick) begin
            if (st.stage_cnt == 13'h0001) begin
              next_st.stage     = (st.stage == PRE1) ? ACQ1 : ACQ2;
              next_st.stage_cnt = ACQ_LOAD;
            end else begin
              next_st.stage_cnt = st.stage_cnt - 13'h0001;
            end
          end
        end
        ACQ1, ACQ2: begin
          if (tick) begin
            if (st.stage_cnt == 13'h0001) begin
              next_st.stage      = (st.stage == ACQ1) ? CONV1 : CONV2;
              next_st.conv_start = 1'b1;
            end else begin
              next_st.stage_cnt = st.stage_cnt - 13'h0001;
            end
          end
        end
        CONV1, CONV2: begin
          if (i_conv_done) begin
            next_st.result = {4'h0, i_conv_data};
            if (st.stage == CONV1 && st.samp_ctl[BIT_DOUBLE_SAMPLE_ENABLE]) begin
              next_st.previous      = {4'h0, i_conv_data}; // R03
              next_st.stage         = PRE2; // R03
              next_st.stage_cnt     = PRE_LOAD;
              next_st.precharge_lvl = st.samp_ctl[BIT_PRECHARGE_POLARITY] ^ pol_flip; // R01
              next_st.guard_lvl     = st.samp_ctl[BIT_GUARD_POLARITY] ^ pol_flip; // R01
            end else begin
              next_st.stage = IDLE;
              finish        = 1'b1;
            end
          end
        end
      endcase
    end

    // Computation at the end of a trigger
    if (finish) begin
      unique case (mode) // R10
        MODE_ACCUMULATE: begin
          sum   = {1'b0, st.accumulator} + {1'b0, sample};
          check = 1'b1;
        end
        MODE_AVERAGE, MODE_BURST: begin
          sum   = (st.repeat_counter >= st.repeat_target) ? {1'b0, sample}
                                                          : {1'b0, st.accumulator} + {1'b0, sample};
          check = ((st.repeat_counter >= st.repeat_target) ? 8'h01 : cnt_inc) >= st.repeat_target;
        end
        MODE_LOWPASS: begin
          sum   = {1'b0, st.accumulator} + {1'b0, sample} - {1'b0, st.accumulator >> sh}; // R05
          check = cnt_inc >= st.repeat_target;
        end
        default: check = 1'b1; // Basic and reserved codes
      endcase
      if (mode == MODE_ACCUMULATE || mode == MODE_AVERAGE || mode == MODE_BURST || mode == MODE_LOWPASS) begin
        next_st.accumulator    = sum[17:0];
        next_st.filter_output  = shift_out(sum[17:0], sh); // R06
        next_st.repeat_counter = ((mode == MODE_AVERAGE || mode == MODE_BURST) &&
                                  st.repeat_counter >= st.repeat_target) ? 8'h01 : cnt_inc;
        next_st.computation_status           = 1'b1; // R16
        if (sum[18]) begin
          next_st.accumulator_overflow = 1'b1; // R14
        end
        err = shift_out(sum[17:0], sh);
      end else begin
        err = {4'h0, i_conv_data};
      end
      if (check) begin
        next_st.upper_flag = $signed({1'b0, err}) > $signed({st.upper_limit[15], st.upper_limit}); // R15
        next_st.lower_flag = $signed({1'b0, err}) < $signed({st.lower_limit[15], st.lower_limit}); // R15
        next_st.computation_status       = 1'b1; // R16
        hit                = thr_hit(st.thr_ctl[2:0], err, st.upper_limit, st.lower_limit); // R13
        next_st.thr_event  = hit;
      end
      // Burst average keeps the trigger open until the repeat target is met
      if (mode != MODE_BURST || check) begin
        if (!st.conv_ctl[BIT_CONTINUOUS]) begin
          next_st.conv_ctl[BIT_GO] = 1'b0; // R20
        end else if (st.thr_ctl[BIT_SOI] && hit) begin // R12
          next_st.conv_ctl[BIT_GO] = 1'b0; // R11
        end
      end
    end

    // Clear waits for a tick, so it lags slow clocks; a finishing computation defers it
    if (st.comp_ctl[BIT_ACCUMULATOR_CLEAR_CMD] && tick && !finish) begin
      next_st.accumulator          = 18'h00000; // R08
      next_st.accumulator_overflow = 1'b0; // R08
      next_st.repeat_counter       = 8'h00; // R08
      next_st.comp_ctl[BIT_ACCUMULATOR_CLEAR_CMD]   = 1'b0; // R09
      next_st.computation_status                 = 1'b1; // R16
    end

    // Register reads, answered in the next cycle
    if (i_rd) begin
      unique case (i_addr)
        OFS_CONVERSION_CONTROL: next_st.rd_data = st.conv_ctl;
        OFS_SAMPLING_CONTROL:   next_st.rd_data = st.samp_ctl;
        OFS_COMPUTE_CONTROL:    next_st.rd_data = st.comp_ctl;
        OFS_THRESHOLD_CONTROL:  next_st.rd_data = st.thr_ctl;
        OFS_CONVERTER_STATUS:   next_st.rd_data = {st.accumulator_overflow, st.upper_flag, st.lower_flag,
                                                   st.computation_status, 1'b0, stage_code(st.stage)}; // R17
        OFS_REFERENCE_SELECT:   next_st.rd_data = st.ref_sel;
        OFS_CLOCK_DIVIDER:      next_st.rd_data = st.clk_div;
        OFS_REPEAT_TARGET:      next_st.rd_data = st.repeat_target;
        OFS_REPEAT_COUNTER:     next_st.rd_data = st.repeat_counter;
        OFS_LOWER_LIMIT_L:      next_st.rd_data = st.lower_limit[7:0];
        OFS_LOWER_LIMIT_H:      next_st.rd_data = st.lower_limit[15:8];
        OFS_UPPER_LIMIT_L:      next_st.rd_data = st.upper_limit[7:0];
        OFS_UPPER_LIMIT_H:      next_st.rd_data = st.upper_limit[15:8];
        OFS_FILTER_L:           next_st.rd_data = st.filter_output[7:0];
        OFS_FILTER_H:           next_st.rd_data = st.filter_output[15:8];
        OFS_ACCUM_L:            next_st.rd_data = st.accumulator[7:0];
        OFS_ACCUM_H:            next_st.rd_data = st.accumulator[15:8];
        OFS_ACCUM_U:            next_st.rd_data = {6'h00, st.accumulator[17:16]};
        OFS_PREVIOUS_L:         next_st.rd_data = st.previous[7:0];
        OFS_PREVIOUS_H:         next_st.rd_data = st.previous[15:8];
        OFS_RESULT_L:           next_st.rd_data = st.result[7:0];
        OFS_RESULT_H:           next_st.rd_data = st.result[15:8];
        default:                next_st.rd_data = 8'h00;
      endcase
    end
    next_st.busy = next_st.stage != IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st       <= '0;
      st.stage <= IDLE;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rd_data         = st.rd_data;
  assign o_threshold_event = st.thr_event;
  assign o_analog          = '{precharge_level:  st.precharge_lvl,
                               guard_level:      st.guard_lvl,
                               neg_ref_external: st.ref_sel[BIT_NEGATIVE_REFERENCE_SELECT], // R19
                               conv_start:       st.conv_start,
                               conv_clk:         st.conv_clk,
                               busy:             st.busy};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_single_go_clear: assert property (@(posedge i_clk) disable iff (i_rst) // R20
    (i_ce && finish && !st.conv_ctl[BIT_CONTINUOUS] && check && !i_wr) |=> !st.conv_ctl[BIT_GO])
    else $error("go not cleared after single trigger");
  a_soi_stop: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (i_ce && finish && st.conv_ctl[BIT_CONTINUOUS] && st.thr_ctl[BIT_SOI] && hit && !i_wr)
    |=> !st.conv_ctl[BIT_GO])
    else $error("go not cleared on threshold stop");
  a_continuous_operation_keep_go: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    (i_ce && finish && st.conv_ctl[BIT_CONTINUOUS] && !st.thr_ctl[BIT_SOI] && !i_wr)
    |=> st.conv_ctl[BIT_GO])
    else $error("go cleared by hardware in continuous run");
  a_double_pass: assert property (@(posedge i_clk) disable iff (i_rst) // R03
    (i_ce && st.stage == CONV1 && i_conv_done && st.conv_ctl[BIT_GO] && st.samp_ctl[BIT_DOUBLE_SAMPLE_ENABLE])
    |=> st.stage == PRE2 && st.previous == {4'h0, $past(i_conv_data)})
    else $error("double sample did not start second pass");
  a_previous_source: assert property (@(posedge i_clk) disable iff (i_rst) // R04
    (i_ce && st.stage == IDLE && next_st.stage == PRE1)
    |=> st.previous == ($past(st.comp_ctl[BIT_PREVIOUS_SOURCE_SELECT]) ? $past(st.filter_output) : $past(st.result)))
    else $error("previous result copied from wrong source");
  a_second_polarity: assert property (@(posedge i_clk) disable iff (i_rst) // R01
    (st.stage == PRE2 && $stable(st.samp_ctl)) |->
    o_analog.guard_level == (st.samp_ctl[BIT_GUARD_POLARITY] ^ st.samp_ctl[BIT_INVERTED_PRECHARGE_ENABLE]) &&
    o_analog.precharge_level == (st.samp_ctl[BIT_PRECHARGE_POLARITY] ^ st.samp_ctl[BIT_INVERTED_PRECHARGE_ENABLE]))
    else $error("second pass polarity wrong");
  a_clear_done: assert property (@(posedge i_clk) disable iff (i_rst) // R08
    (i_ce && st.comp_ctl[BIT_ACCUMULATOR_CLEAR_CMD] && tick && !finish && !i_wr)
    |=> st.accumulator == 18'h00000 && st.repeat_counter == 8'h00 && !st.accumulator_overflow &&
        !st.comp_ctl[BIT_ACCUMULATOR_CLEAR_CMD])
    else $error("accumulator clear incomplete");
  a_divider_wrap: assert property (@(posedge i_clk) disable iff (i_rst) // R21
    (i_ce && !st.conv_ctl[BIT_CLOCK_SELECT] && st.div_cnt < st.clk_div[5:0]) |=> $stable(st.conv_clk))
    else $error("conversion clock toggled before wrap");
  a_computation_status_update: assert property (@(posedge i_clk) disable iff (i_rst) // R16
    (i_ce && finish && st.comp_ctl[2:0] == MODE_ACCUMULATE) |=> st.computation_status)
    else $error("computation status not set");

endmodule // adc_compute_control

/* File: verif/adc_compute_control_bench.sv */
/*
  Bench for adc_compute_control: register read and write tasks, conversion sequences, expected values.
  Assumes one 50 MHz clock, the fosc-derived conversion clock, and the bench standing in for the analog core.
*/
`timescale 1ns/100ps
module adc_compute_control_bench;
  import adc_compute_pkg::*;
  logic         i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_conv_done = 1'b0;
  logic [11:0]  i_addr = 12'h000, i_conv_data = 12'h000;
  logic [7:0]   i_wr_data = 8'h00, o_rd_data;
  analog_ctrl_s o_analog;
  logic         o_threshold_event;
  int           miscompares = 0, n_compared = 0, events = 0;

  always #10 i_clk = ~i_clk;
  always @(negedge i_clk) if (o_threshold_event === 1'b1) events++;

  // Short stages keep each conversion a few cycles long
  adc_compute_control #(.PRE_TICKS(1), .ACQ_TICKS(1)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
    .i_rd(i_rd), .o_rd_data(o_rd_data), .i_dedicated_osc(1'b0), .i_conv_done(i_conv_done),
    .i_conv_data(i_conv_data), .o_analog(o_analog), .o_threshold_event(o_threshold_event));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rd_data;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Bounded wait: sel 0 for busy, 1 for the start pulse
  task automatic wait_for(input bit sel);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while ((sel ? o_analog.conv_start : o_analog.busy) !== 1'b1 && n < 200);
    if (n >= 200) chk(8'h00, 8'h01);
  endtask
  task automatic finish_conv(input logic [11:0] d);
    @(posedge i_clk);
    i_conv_done <= 1'b1;
    i_conv_data <= d;
    @(posedge i_clk);
    i_conv_done <= 1'b0;
  endtask
  task automatic convert(input logic [11:0] d);
    wr(OFS_CONVERSION_CONTROL, 8'h81);
    wait_for(1);
    finish_conv(d);
    repeat (3) @(posedge i_clk);
  endtask
  task automatic clear_to(input logic [7:0] c);
    logic [7:0] v;
    int         n;
    wr(OFS_COMPUTE_CONTROL, c);
    n = 0;
    do begin
      rd(OFS_COMPUTE_CONTROL, v);
      n++;
    end while (v[3] !== 1'b0 && n < 50);
    chk(v, c & 8'hF7);
  endtask
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  initial begin
    logic [7:0]  v;
    logic [11:0] offs [5];
    int          k;
    offs = '{OFS_COMPUTE_CONTROL, OFS_THRESHOLD_CONTROL, OFS_CONVERTER_STATUS, OFS_REFERENCE_SELECT, OFS_CLOCK_DIVIDER};
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (offs[i]) rc(offs[i], REG_RESET);
    rc(12'h117, 8'h00);
    wr(OFS_REFERENCE_SELECT, 8'h11);
    rc(OFS_REFERENCE_SELECT, 8'h11);
    chk({7'h00, o_analog.neg_ref_external}, 8'h01);
    $display("Test registers done");
    wr(OFS_SAMPLING_CONTROL, 8'hA0);
    wr(OFS_CONVERSION_CONTROL, 8'h81);
    wait_for(0);
    chk({6'h00, o_analog.precharge_level, o_analog.guard_level}, 8'h03);
    wait_for(1);
    rd(OFS_CONVERTER_STATUS, v);
    chk(v & 8'h07, 8'h03);
    finish_conv(12'h123);
    repeat (3) @(posedge i_clk);
    rc(OFS_RESULT_L, 8'h23);
    rc(OFS_RESULT_H, 8'h01);
    rc(OFS_CONVERSION_CONTROL, 8'h80);
    $display("Test single conversion done");
    wr(OFS_SAMPLING_CONTROL, 8'hE1);
    wr(OFS_CONVERSION_CONTROL, 8'h81);
    wait_for(1);
    finish_conv(12'h055);
    @(negedge i_clk);
    chk({6'h00, o_analog.precharge_level, o_analog.guard_level}, 8'h00);
    wait_for(1);
    finish_conv(12'h0AA);
    repeat (3) @(posedge i_clk);
    rc(OFS_PREVIOUS_L, 8'h55);
    rc(OFS_RESULT_L, 8'hAA);
    $display("Test double sample done");
    wr(OFS_SAMPLING_CONTROL, 8'h00);
    wr(OFS_REPEAT_TARGET, 8'h02);
    clear_to(8'h99);
    rc(OFS_REPEAT_COUNTER, 8'h00);
    rc(OFS_ACCUM_H, 8'h00);
    convert(12'h100);
    convert(12'h200);
    rc(OFS_REPEAT_COUNTER, 8'h02);
    rc(OFS_ACCUM_H, 8'h03);
    rc(OFS_FILTER_L, 8'h80);
    rc(OFS_FILTER_H, 8'h01);
    rc(OFS_PREVIOUS_L, 8'h80);
    rc(OFS_CONVERTER_STATUS, 8'h50);
    wr(OFS_CONVERTER_STATUS, 8'h00);
    rc(OFS_CONVERTER_STATUS, 8'h40);
    $display("Test accumulate done");
    wr(OFS_THRESHOLD_CONTROL, 8'h0F);
    k = events;
    wr(OFS_CONVERSION_CONTROL, 8'hC1);
    wait_for(1);
    finish_conv(12'h010);
    repeat (3) @(posedge i_clk);
    rc(OFS_CONVERSION_CONTROL, 8'hC0);
    chk(8'(events - k), 8'h01);
    wr(OFS_THRESHOLD_CONTROL, 8'h07);
    wr(OFS_CONVERSION_CONTROL, 8'hC1);
    wait_for(1);
    finish_conv(12'h010);
    wait_for(1);
    rc(OFS_CONVERSION_CONTROL, 8'hC1);
    wr(OFS_CONVERSION_CONTROL, 8'h80);
    $display("Test continuous done");
    wr(OFS_LOWER_LIMIT_L, 8'hFF);
    clear_to(8'h1C);
    rc(OFS_ACCUM_H, 8'h00);
    rc(OFS_REPEAT_COUNTER, 8'h00);
    k = events;
    convert(12'h100);
    convert(12'h100);
    rc(OFS_FILTER_L, 8'hC0);
    rc(OFS_FILTER_H, 8'h00);
    rc(OFS_CONVERTER_STATUS, 8'h70);
    chk(8'(events - k), 8'h01);
    $display("Test low-pass done");
    wr(OFS_CLOCK_DIVIDER, 8'h02);
    rc(OFS_CLOCK_DIVIDER, 8'h02);
    k = 0;
    v[1] = o_analog.conv_clk;
    repeat (60) begin
      @(negedge i_clk);
      if (o_analog.conv_clk === 1'b1 && v[1] === 1'b0) k++;
      v[1] = o_analog.conv_clk;
    end
    chk(8'(k), 8'h0A);
    $display("Test clock divider done");
    conclude();
  end
endmodule // adc_compute_control_bench
